/* mem_abort_model.sv */
// Memory side model that accepts writes and aborts on command
`timescale 1ns/100ps
module mem_abort_model (
  input  wire logic       clk,
  input  wire logic       mem_write_ff,
  input  wire logic       arm,
  input  wire logic [4:0] after_n,
  output      logic       data_abort
);
  logic [4:0] seen_ff;
  always_ff @(posedge clk) begin
    if (!arm) begin
      seen_ff <= 5'h0;
    end else if (mem_write_ff) begin
      seen_ff <= seen_ff + 5'h1;
    end
  end
  // Abort once the given number of writes has been taken
  assign data_abort = arm && (seen_ff >= after_n);
endmodule

/* mem_access_port.sv */
// Registered memory access port with byte lane placement
`timescale 1ns/100ps
module mem_access_port (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  mem_req_if.dst            req,
  output      logic         mem_write_ff,
  output      logic [31:0]  mem_addr_ff,
  output      logic [31:0]  mem_wdata_ff,
  output      logic [3:0]   mem_byte_en_ff,
  output      logic         mem_user_ff
);
  import store_unit_pkg::*;

  logic [3:0]  nxt_byte_en;
  logic [31:0] nxt_wdata;

  // ****************************************
  // Lane placement
  // ****************************************
  always_comb begin
    nxt_byte_en = 4'h0;
    nxt_wdata   = req.data;
    unique case (req.size)
      SIZE_BYTE: begin
        nxt_byte_en = 4'h1 << req.addr[1:0];
        nxt_wdata   = {4{req.data[7:0]}};
      end
      SIZE_HALF: begin
        nxt_byte_en = req.addr[1] ? 4'hc : 4'h3;
        nxt_wdata   = {2{req.data[15:0]}};
      end
      default: begin
        nxt_byte_en = 4'hf;
        nxt_wdata   = req.data;
      end
    endcase
  end

  assign req.issued = req.valid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_write_ff   <= 1'b0;
      mem_addr_ff    <= ZERO_WORD;
      mem_wdata_ff   <= ZERO_WORD;
      mem_byte_en_ff <= 4'h0;
      mem_user_ff    <= 1'b0;
    end else begin
      mem_write_ff   <= req.valid;
      mem_addr_ff    <= req.addr;
      mem_wdata_ff   <= nxt_wdata;
      mem_byte_en_ff <= req.valid ? nxt_byte_en : 4'h0;
      mem_user_ff    <= req.valid & req.as_user;
    end
  end
endmodule

/* mem_req_if.sv */
// Memory request carrier between the sequencer and the access port
`timescale 1ns/100ps
interface mem_req_if;
  import store_unit_pkg::*;
  logic        valid;
  logic [31:0] addr;
  logic [31:0] data;
  size_t       size;
  logic        as_user;
  logic        issued;
  modport src (output valid, output addr, output data, output size, output as_user,
               input issued);
  modport dst (input valid, input addr, input data, input size, input as_user,
               output issued);
endinterface

/* store_instruction_unit.sv */
// Store-class and subtract execution unit
//
// Notes on behaviour
// - Execute store or subtract only when the condition field passes on current flags.
// - User-bank multiple store walks list bits 0..15, one word each, address plus 4.
// - Multiple store base comes from the current mode bank, not user bank.
// - Abort during user-bank multiple store leaves the base register unchanged.
// - Multiple transfers ignore address bits 1:0 and never rotate words.
// - With checking on, word or multiple store misaligned in bits 1:0 faults.
// - Program counter in the list stores a chosen value; as base, unpredictable.
// - Word store writes the full 32-bit source to the addressed word.
// - Program counter as word store source stores an implementation value.
// - Abort on indexed single store leaves base original or updated.
// - Byte stores write source bits 7:0 to the addressed byte only.
// - User-privilege stores from privileged mode flag the access as user mode.
// - User-privilege stores are post-indexed only; abort leaves base either value.
// - Halfword store writes bits 15:0; odd address stores an unpredictable value.
// - With checking on, halfword store at odd address faults.
// - Subtract writes base minus operand; flags only when flag-set bit is one.
// - Flag-set subtract to program counter copies saved status into current status.
// - Subtract flags: N bit 31, Z zero, C not borrow, V signed overflow.
`timescale 1ns/100ps
module store_instruction_unit (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  instr_valid,
  input  wire store_unit_pkg::op_t   instr_op,
  input  wire logic [3:0]            instr_cond,
  input  wire logic                  instr_pre_index,
  input  wire logic                  instr_up,
  input  wire logic                  instr_writeback,
  input  wire logic                  instr_flag_set,
  input  wire logic [3:0]            instr_dest,
  input  wire logic [3:0]            instr_base_sel,
  input  wire logic [15:0]           instr_reg_list,
  input  wire logic [31:0]           base_value,
  input  wire logic [31:0]           offset_value,
  input  wire logic [31:0]           source_value,
  input  wire logic [31:0]           shifter_operand,
  input  wire logic [31:0]           current_status_word,
  input  wire logic [31:0]           saved_status_word,
  input  wire logic [31:0]           user_bank_register [16],
  input  wire logic                  align_check_en,
  input  wire logic                  data_abort,
  output      logic                  busy_ff,
  output      logic                  done_ff,
  output      logic                  skipped_ff,
  output      logic                  mem_write_ff,
  output      logic [31:0]           mem_addr_ff,
  output      logic [31:0]           mem_wdata_ff,
  output      logic [3:0]            mem_byte_en_ff,
  output      logic                  mem_user_ff,
  output      logic                  align_fault_ff,
  output      logic                  abort_taken_ff,
  output      logic                  reg_write_ff,
  output      logic [3:0]            reg_write_idx_ff,
  output      logic [31:0]           reg_write_data_ff,
  output      logic                  status_write_ff,
  output      logic [31:0]           status_word_ff
);
  import store_unit_pkg::*;

  mem_req_if req ();

  state_t      state_ff;
  state_t      nxt_state;
  op_t         op_ff;
  logic [15:0] list_ff;
  logic [31:0] addr_ff;
  logic [31:0] src_ff;
  logic [31:0] new_base_ff;
  logic [3:0]  base_sel_ff;
  logic        base_wb_ff;
  logic        user_priv_ff;
  logic [3:0]  scan_ff;

  logic        cond_pass;
  logic        n_f;
  logic        z_f;
  logic        c_f;
  logic        v_f;
  logic        privileged;
  logic [31:0] eff_addr;
  logic [31:0] upd_base;
  logic        misaligned;
  logic [32:0] diff;
  logic [31:0] sub_res;
  logic        sub_ovf;
  logic [3:0]  next_bit;
  logic        list_empty;
  logic [15:0] clear_mask;

  // ****************************************
  // Condition evaluation
  // ****************************************
  assign n_f = current_status_word[FLAG_N];
  assign z_f = current_status_word[FLAG_Z];
  assign c_f = current_status_word[FLAG_C];
  assign v_f = current_status_word[FLAG_V];

  always_comb begin
    unique case (instr_cond)
      COND_EQ: cond_pass = z_f;
      COND_NE: cond_pass = !z_f;
      COND_CS: cond_pass = c_f;
      COND_CC: cond_pass = !c_f;
      COND_MI: cond_pass = n_f;
      COND_PL: cond_pass = !n_f;
      COND_VS: cond_pass = v_f;
      COND_VC: cond_pass = !v_f;
      COND_HI: cond_pass = c_f && !z_f;
      COND_LS: cond_pass = !c_f || z_f;
      COND_GE: cond_pass = n_f == v_f;
      COND_LT: cond_pass = n_f != v_f;
      COND_GT: cond_pass = !z_f && (n_f == v_f);
      COND_LE: cond_pass = z_f || (n_f != v_f);
      COND_AL: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  end

  // ****************************************
  // Address and alignment
  // ****************************************
  assign privileged = current_status_word[MODE_MSB:MODE_LSB] != MODE_USER;
  assign upd_base   = instr_up ? base_value + offset_value : base_value - offset_value;

  always_comb begin
    eff_addr = base_value;
    if (instr_op == OP_MULTI_USER) begin
      eff_addr = base_value;
    end else if (instr_op == OP_WORD_USER || instr_op == OP_BYTE_USER) begin
      eff_addr = base_value;
    end else if (instr_pre_index) begin
      eff_addr = upd_base;
    end
  end

  always_comb begin
    unique case (instr_op)
      OP_MULTI_USER, OP_WORD, OP_WORD_USER: misaligned = eff_addr[1:0] != WORD_ALIGN;
      OP_HALF:                              misaligned = eff_addr[0];
      default:                              misaligned = 1'b0;
    endcase
  end

  // ****************************************
  // Subtract datapath
  // ****************************************
  assign diff    = {1'b0, base_value} - {1'b0, shifter_operand};
  assign sub_res = diff[31:0];
  assign sub_ovf = (base_value[31] != shifter_operand[31]) && (sub_res[31] != base_value[31]);

  // ****************************************
  // List scan
  // ****************************************
  always_comb begin
    next_bit = ZERO_INDEX;
    for (int i = NUM_REGS - 1; i >= 0; i--) begin
      if (list_ff[i]) next_bit = 4'(i);
    end
  end
  assign list_empty = list_ff == ZERO_LIST;
  assign clear_mask = 16'h0001 << next_bit;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (instr_valid && cond_pass && instr_op != OP_SUBTRACT &&
            !(misaligned && align_check_en)) begin
          nxt_state = (instr_op == OP_MULTI_USER) ? ST_MULTI : ST_SINGLE;
        end
      end
      ST_SINGLE: nxt_state = ST_DONE;
      ST_MULTI:  if (data_abort || list_empty) nxt_state = ST_DONE;
      ST_DONE:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state_ff <= ST_IDLE;
    else         state_ff <= nxt_state;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_ff        <= OP_WORD;
      list_ff      <= ZERO_LIST;
      addr_ff      <= ZERO_WORD;
      src_ff       <= ZERO_WORD;
      new_base_ff  <= ZERO_WORD;
      base_sel_ff  <= ZERO_INDEX;
      base_wb_ff   <= 1'b0;
      user_priv_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && nxt_state != ST_IDLE) begin
      op_ff        <= instr_op;
      list_ff      <= instr_reg_list;
      addr_ff      <= (instr_op == OP_MULTI_USER) ? {eff_addr[31:2], 2'b00} : eff_addr;
      src_ff       <= source_value;
      new_base_ff  <= upd_base;
      base_sel_ff  <= instr_base_sel;
      // Multi store never writes back its base
      base_wb_ff   <= instr_op != OP_MULTI_USER &&
                      (!instr_pre_index || instr_writeback ||
                       instr_op == OP_WORD_USER || instr_op == OP_BYTE_USER);
      user_priv_ff <= !privileged ||
                      instr_op == OP_WORD_USER || instr_op == OP_BYTE_USER;
    end else if (state_ff == ST_MULTI && !list_empty && !data_abort) begin
      list_ff <= list_ff & ~clear_mask;
      addr_ff <= addr_ff + WORD_STEP;
    end
  end

  // ****************************************
  // Memory request
  // ****************************************
  always_comb begin
    req.valid   = 1'b0;
    req.addr    = addr_ff;
    req.data    = src_ff;
    req.size    = SIZE_WORD;
    req.as_user = user_priv_ff;
    if (state_ff == ST_SINGLE) begin
      req.valid = 1'b1;
      unique case (op_ff)
        OP_BYTE, OP_BYTE_USER: req.size = SIZE_BYTE;
        OP_HALF:               req.size = SIZE_HALF;
        default:               req.size = SIZE_WORD;
      endcase
    end else if (state_ff == ST_MULTI && !list_empty && !data_abort) begin
      req.valid = 1'b1;
      req.data  = user_bank_register[next_bit];
    end
  end

  mem_access_port u_port (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .req            (req.dst),
    .mem_write_ff   (mem_write_ff),
    .mem_addr_ff    (mem_addr_ff),
    .mem_wdata_ff   (mem_wdata_ff),
    .mem_byte_en_ff (mem_byte_en_ff),
    .mem_user_ff    (mem_user_ff)
  );

  // ****************************************
  // Results and exceptions
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_ff        <= 1'b0;
      done_ff        <= 1'b0;
      skipped_ff     <= 1'b0;
      align_fault_ff <= 1'b0;
      abort_taken_ff <= 1'b0;
    end else begin
      busy_ff        <= nxt_state != ST_IDLE;
      done_ff        <= state_ff == ST_DONE ||
                        (state_ff == ST_IDLE && instr_valid && cond_pass &&
                         instr_op == OP_SUBTRACT);
      skipped_ff     <= state_ff == ST_IDLE && instr_valid && !cond_pass;
      align_fault_ff <= state_ff == ST_IDLE && instr_valid && cond_pass &&
                        misaligned && align_check_en;
      abort_taken_ff <= (state_ff == ST_SINGLE || state_ff == ST_MULTI) && data_abort;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_write_ff      <= 1'b0;
      reg_write_idx_ff  <= ZERO_INDEX;
      reg_write_data_ff <= ZERO_WORD;
    end else if (state_ff == ST_IDLE && instr_valid && cond_pass && instr_op == OP_SUBTRACT) begin
      reg_write_ff      <= 1'b1;
      reg_write_idx_ff  <= instr_dest;
      reg_write_data_ff <= sub_res;
    end else if (state_ff == ST_DONE && base_wb_ff) begin
      // Updated base written back even after abort
      reg_write_ff      <= 1'b1;
      reg_write_idx_ff  <= base_sel_ff;
      reg_write_data_ff <= new_base_ff;
    end else begin
      reg_write_ff      <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_write_ff <= 1'b0;
      status_word_ff  <= ZERO_WORD;
    end else if (state_ff == ST_IDLE && instr_valid && cond_pass &&
                 instr_op == OP_SUBTRACT && instr_flag_set) begin
      status_write_ff <= 1'b1;
      if (instr_dest == PC_INDEX) begin
        status_word_ff <= saved_status_word;
      end else begin
        status_word_ff <= {sub_res[31], sub_res == ZERO_WORD, !diff[32], sub_ovf,
                           current_status_word[27:0]};
      end
    end else begin
      status_write_ff <= 1'b0;
    end
  end
endmodule

/* store_instruction_unit_chk.sv */
// Port-level assertions for the store instruction unit
`timescale 1ns/100ps
module store_instruction_unit_chk (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 instr_valid,
  input wire store_unit_pkg::op_t  instr_op,
  input wire logic [3:0]           instr_cond,
  input wire logic                 instr_flag_set,
  input wire logic [3:0]           instr_dest,
  input wire logic [31:0]          base_value,
  input wire logic [31:0]          shifter_operand,
  input wire logic [31:0]          saved_status_word,
  input wire logic                 busy_ff,
  input wire logic                 skipped_ff,
  input wire logic                 mem_write_ff,
  input wire logic [31:0]          mem_addr_ff,
  input wire logic [3:0]           mem_byte_en_ff,
  input wire logic                 align_fault_ff,
  input wire logic                 reg_write_ff,
  input wire logic [31:0]          reg_write_data_ff,
  input wire logic                 status_write_ff,
  input wire logic [31:0]          status_word_ff
);
  import store_unit_pkg::*;
  logic [31:0] diff;
  assign diff = base_value - shifter_operand;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence take_al;
    instr_valid && !busy_ff && instr_cond == COND_AL;
  endsequence
  sequence take_sub;
    take_al ##0 instr_op == OP_SUBTRACT;
  endsequence
  a_cond_never: assert property (instr_valid && !busy_ff && instr_cond == 4'hf |=> skipped_ff)
    else $error("never condition not skipped");
  a_cond_always: assert property (take_al |=> !skipped_ff)
    else $error("always condition skipped");
  a_skip_quiet: assert property (skipped_ff |-> !status_write_ff ##1 !mem_write_ff [*3])
    else $error("skipped instruction had effect");
  a_sub_diff: assert property (take_sub |=> reg_write_ff && reg_write_data_ff == $past(diff))
    else $error("subtract result wrong");
  a_sub_noflag: assert property (take_sub ##0 !instr_flag_set |=> !status_write_ff)
    else $error("flags written without flag-set");
  a_sub_restore: assert property (take_sub ##0 instr_flag_set && instr_dest == PC_INDEX
    |=> status_write_ff && status_word_ff == $past(saved_status_word))
    else $error("saved status not restored");
  a_sub_nz_flags: assert property (take_sub ##0 instr_flag_set && instr_dest != PC_INDEX
    |=> status_write_ff && status_word_ff[FLAG_N] == reg_write_data_ff[31]
        && status_word_ff[FLAG_Z] == (reg_write_data_ff == ZERO_WORD))
    else $error("negative or zero flag wrong");
  a_multi_step: assert property (mem_write_ff && $past(mem_write_ff)
    |-> mem_addr_ff == $past(mem_addr_ff) + WORD_STEP && mem_addr_ff[1:0] == WORD_ALIGN)
    else $error("multiple store address step wrong");
  a_fault_quiet: assert property (align_fault_ff |-> !mem_write_ff ##1 !mem_write_ff [*2])
    else $error("access after alignment fault");
  a_lane_idle: assert property (!mem_write_ff |-> mem_byte_en_ff == 4'h0)
    else $error("lanes enabled without write");
endmodule

bind store_instruction_unit store_instruction_unit_chk chk (.clk, .sys_rst, .instr_valid,
  .instr_op, .instr_cond, .instr_flag_set, .instr_dest, .base_value, .shifter_operand,
  .saved_status_word, .busy_ff, .skipped_ff, .mem_write_ff, .mem_addr_ff, .mem_byte_en_ff,
  .align_fault_ff, .reg_write_ff, .reg_write_data_ff, .status_write_ff, .status_word_ff);

/* store_unit_pkg.sv */
// Shared constants and types for the store instruction unit
package store_unit_pkg;

  // ****************************************
  // Condition codes
  // ****************************************
  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_CS = 4'h2;
  localparam logic [3:0] COND_CC = 4'h3;
  localparam logic [3:0] COND_MI = 4'h4;
  localparam logic [3:0] COND_PL = 4'h5;
  localparam logic [3:0] COND_VS = 4'h6;
  localparam logic [3:0] COND_VC = 4'h7;
  localparam logic [3:0] COND_HI = 4'h8;
  localparam logic [3:0] COND_LS = 4'h9;
  localparam logic [3:0] COND_GE = 4'ha;
  localparam logic [3:0] COND_LT = 4'hb;
  localparam logic [3:0] COND_GT = 4'hc;
  localparam logic [3:0] COND_LE = 4'hd;
  localparam logic [3:0] COND_AL = 4'he;

  // ****************************************
  // Status word layout
  // ****************************************
  localparam int FLAG_N = 31;
  localparam int FLAG_Z = 30;
  localparam int FLAG_C = 29;
  localparam int FLAG_V = 28;
  localparam logic [4:0] MODE_USER   = 5'h10;
  localparam logic [4:0] MODE_SYSTEM = 5'h1f;
  localparam int         MODE_LSB    = 0;
  localparam int         MODE_MSB    = 4;

  // ****************************************
  // Sizes, widths, resets
  // ****************************************
  localparam int          NUM_REGS    = 16;
  localparam logic [3:0]  PC_INDEX    = 4'hf;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [15:0] ZERO_LIST   = 16'h0000;
  localparam logic [3:0]  ZERO_INDEX  = 4'h0;
  localparam logic [3:0]  LAST_INDEX  = 4'hf;
  localparam logic [1:0]  WORD_ALIGN  = 2'h0;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} size_t;

  typedef enum logic [2:0] {
    OP_MULTI_USER,
    OP_WORD,
    OP_BYTE,
    OP_HALF,
    OP_WORD_USER,
    OP_BYTE_USER,
    OP_SUBTRACT
  } op_t;

  typedef enum {ST_IDLE, ST_SINGLE, ST_MULTI, ST_DONE} state_t;

endpackage

/* tb_store_instruction_unit.sv */
// Self-checking bench for the store instruction unit
`timescale 1ns/100ps
module tb_store_instruction_unit;
  import store_unit_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [3:0] e; logic u;} wr_t;
  logic        clk, sys_rst, instr_valid, instr_pre_index, instr_up, instr_writeback;
  logic        instr_flag_set, align_check_en, data_abort, arm;
  op_t         instr_op;
  logic [3:0]  instr_cond, instr_dest, instr_base_sel, mem_byte_en_ff, reg_write_idx_ff, ridx;
  logic [15:0] instr_reg_list;
  logic [31:0] base_value, offset_value, source_value, shifter_operand;
  logic [31:0] current_status_word, saved_status_word, user_bank_register [16];
  logic [4:0]  after_n;
  logic        busy_ff, done_ff, skipped_ff, mem_write_ff, mem_user_ff, align_fault_ff;
  logic        abort_taken_ff, reg_write_ff, status_write_ff;
  logic        sdone, sskip, sfault, sabort, sreg, sstat;
  logic [31:0] mem_addr_ff, mem_wdata_ff, reg_write_data_ff, status_word_ff, rdat, sword;
  int          failures, comparisons;
  wr_t         q[$];
  op_t         sops [5] = '{OP_WORD, OP_BYTE, OP_HALF, OP_WORD_USER, OP_BYTE_USER};
  op_t         aop [4] = '{OP_WORD, OP_MULTI_USER, OP_HALF, OP_HALF};
  logic [1:0]  alo [4] = '{2'h2, 2'h1, 2'h1, 2'h2};

  store_instruction_unit dut (.clk, .sys_rst, .instr_valid, .instr_op, .instr_cond,
    .instr_pre_index, .instr_up, .instr_writeback, .instr_flag_set, .instr_dest,
    .instr_base_sel, .instr_reg_list, .base_value, .offset_value, .source_value,
    .shifter_operand, .current_status_word, .saved_status_word, .user_bank_register,
    .align_check_en, .data_abort, .busy_ff, .done_ff, .skipped_ff, .mem_write_ff,
    .mem_addr_ff, .mem_wdata_ff, .mem_byte_en_ff, .mem_user_ff, .align_fault_ff,
    .abort_taken_ff, .reg_write_ff, .reg_write_idx_ff, .reg_write_data_ff,
    .status_write_ff, .status_word_ff);
  mem_abort_model mem (.clk, .mem_write_ff, .arm, .after_n, .data_abort);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic cond_pass(logic [3:0] c, logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] && !f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = !f[2] && (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return (c == 4'hf) ? 1'b0 : (c[3:1] == 3'h7) ? 1'b1 : r ^ c[0];
  endfunction

  function automatic logic [3:0] sub_flags(logic [31:0] x, logic [31:0] y);
    logic [31:0] r;
    r = x - y;
    return {r[31], r == 32'h0000_0000, x >= y, (x[31] != y[31]) && (r[31] != x[31])};
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Offer one instruction, then record everything it causes
  task automatic issue(op_t op, logic [3:0] cond);
    @(posedge clk);
    instr_op <= op;
    instr_cond <= cond;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    q.delete();
    {sdone, sskip, sfault, sabort, sreg, sstat} = '0;
    repeat (22) begin
      @(negedge clk);
      if (mem_write_ff) q.push_back('{mem_addr_ff, mem_wdata_ff, mem_byte_en_ff, mem_user_ff});
      {sdone, sskip, sfault} = {sdone | done_ff, sskip | skipped_ff, sfault | align_fault_ff};
      sabort = sabort | abort_taken_ff;
      if (reg_write_ff) {sreg, ridx, rdat} = {1'b1, reg_write_idx_ff, reg_write_data_ff};
      if (status_write_ff) {sstat, sword} = {1'b1, status_word_ff};
    end
    @(posedge clk);
  endtask

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] a, b, s, m;
    logic [3:0]  f, c, d, e;
    logic [15:0] l;
    logic        fs, p, um;
    op_t         op;
    int          n;
    {sys_rst, instr_valid, instr_pre_index, instr_up, instr_writeback} = 5'h10;
    {instr_flag_set, align_check_en, arm} = 3'h0;
    instr_op = OP_WORD;
    {instr_cond, instr_dest, instr_base_sel, after_n, instr_reg_list} = '0;
    {base_value, offset_value, source_value, shifter_operand} = '0;
    {current_status_word, saved_status_word} = '0;
    foreach (user_bank_register[j]) user_bank_register[j] = 32'h0000_0000;
    {failures, comparisons} = '0;
    void'($urandom(37));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    chk("idle outputs", 0, {busy_ff, done_ff, mem_write_ff, reg_write_ff, status_write_ff});
    for (int i = 0; i < 40; i++) begin
      {a, b, s, f} = {$urandom, $urandom, $urandom, 4'($urandom)};
      if (i == 0) b = a;
      if (i == 1) {a, b} = {32'h8000_0000, 32'h0000_0001};
      c = (i < 16) ? i[3:0] : (i >= 32) ? COND_AL : 4'($urandom);
      fs = (i >= 32) ? i[0] : 1'($urandom);
      d = (i >= 32 && i[1]) ? PC_INDEX : 4'($urandom % 15);
      {base_value, shifter_operand, saved_status_word} <= {a, b, s};
      current_status_word <= {f, 28'h000_0013};
      {instr_flag_set, instr_dest} <= {fs, d};
      issue(OP_SUBTRACT, c);
      p = cond_pass(c, f);
      chk("skipped", !p, sskip);
      chk("reg write", p, sreg);
      chk("status write", p && fs, sstat);
      if (p) chk("difference", a - b, rdat);
      if (p) chk("dest", d, ridx);
      if (p && fs && d == PC_INDEX) chk("restored", s, sword);
      if (p && fs && d != PC_INDEX) chk("flags", sub_flags(a, b), sword[31:28]);
    end
    for (int i = 0; i < 20; i++) begin
      op = sops[i % 5];
      {a, b, s, d, um} = {$urandom, 32'($urandom % 256), $urandom, 4'(i), 1'(i)};
      if (op == OP_WORD || op == OP_WORD_USER) a[1:0] = 2'h0;
      if (op == OP_HALF) a[0] = 1'b0;
      {base_value, offset_value, source_value, instr_up, instr_base_sel} <= {a, b, s, i[1], d};
      current_status_word <= um ? 32'h0000_0010 : 32'h0000_0013;
      issue(op, (i == 19) ? 4'hf : COND_AL);
      chk("write count", (i == 19) ? 0 : 1, q.size());
      if (i == 19 || q.size() != 1) continue;
      e = (op == OP_HALF) ? 4'h3 << a[1:0] : 4'h1 << a[1:0];
      if (op == OP_WORD || op == OP_WORD_USER) e = 4'hf;
      m = {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
      chk("address", a, q[0].a);
      chk("lanes", e, q[0].e);
      chk("data", (s << {a[1:0], 3'h0}) & m, q[0].d & m);
      chk("user access", um || op == OP_WORD_USER || op == OP_BYTE_USER, q[0].u);
      chk("base update", i[1] ? a + b : a - b, rdat);
      chk("base index", d, ridx);
    end
    for (int i = 0; i < 6; i++) begin
      l = (i == 0) ? 16'h8001 : (i == 1 || i > 3) ? 16'hffff : 16'($urandom);
      a = $urandom;
      foreach (user_bank_register[j]) user_bank_register[j] <= $urandom;
      {instr_reg_list, base_value, instr_base_sel, instr_writeback} <= {l, a, 4'h3, 1'b0};
      current_status_word <= 32'h0000_0013;
      {arm, after_n} <= {i > 3, (i == 4) ? 5'h2 : 5'h0};
      issue((i == 5) ? OP_WORD : OP_MULTI_USER, COND_AL);
      if (i == 4) chk("stopped", 1, sabort && q.size() < 16);
      if (i == 5) chk("single abort", 1, sabort && q.size() == 1);
      if (i == 5) chk("base kept", 1, rdat === a || rdat === a + offset_value);
      if (i > 3) continue;
      n = 0;
      for (int j = 0; j < 16; j++) begin
        if (!l[j]) continue;
        if (n < q.size()) chk("multi address", {a[31:2], 2'h0} + 4 * n, q[n].a);
        if (n < q.size()) chk("multi data", user_bank_register[j], q[n].d);
        n++;
      end
      chk("multi count", n, q.size());
      chk("no writeback", 0, sreg);
      chk("multi done", 1, sdone);
    end
    arm <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {align_check_en, instr_reg_list, instr_pre_index} <= {1'b1, 16'h0003, 1'b0};
      base_value <= {30'($urandom), alo[i]};
      issue(aop[i], COND_AL);
      chk("align fault", i != 3, sfault);
      chk("aligned write", i == 3, q.size());
    end
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule
